// File: rtl/hmp_pkg.sv
package hmp_pkg;
   // ----------------------------------------
   // register offsets on the 3-bit address
   // ----------------------------------------
   localparam logic [2:0] OFS_DATA_LOW  = 3'h0;
   localparam logic [2:0] OFS_DATA_MID  = 3'h1;
   localparam logic [2:0] OFS_DATA_HIGH = 3'h2;
   localparam logic [2:0] OFS_CHAN_EN   = 3'h3;
   localparam logic [2:0] OFS_SYNC_CFG  = 3'h4;
   localparam logic [2:0] OFS_SYNC_TRIG = 3'h5;
   localparam logic [2:0] OFS_ADDR_LOW  = 3'h6;
   localparam logic [2:0] OFS_ACC_CTRL  = 3'h7;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int         ACC_AUTO_INC  = 7;
   localparam int         ACC_BCAST     = 6;
   localparam int         ACC_INSTR_LSB = 2;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [2:0] MODE_SEP      = 3'h0;  // separate_strobe_bus_mode
   localparam logic [2:0] MODE_DS       = 3'h1;  // data_strobe_bus_mode
   // ----------------------------------------
   // carriers and states
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] chan_en;
      logic       pin_sync;
      logic       first_sync_only;
      logic       edge_sens;
      logic       agc_sync_en;
      logic       dc_sync_en;
      logic       noise_sequence_sync_en;
      logic       soft_sync;
   } chan_ctrl_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [9:0]  addr;
      logic [19:0] wdata;
   } int_req_t;
   typedef struct packed {
      logic       cs_n;
      logic       rd_ds_n;
      logic       wr_rw_n;
      logic [2:0] addr;
      logic [7:0] data;
      logic [2:0] mode;
      logic [1:0] id;
   } pins_t;
   localparam pins_t PINS_IDLE = '{cs_n: 1'b1, rd_ds_n: 1'b1, wr_rw_n: 1'b1, default: '0};
   typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_INT, ST_DONE} state_t;
endpackage

// File: rtl/host_microport.sv
// Operation
// - 8-bit data bus, 3-bit register address
// - two strobe protocols, roles swap per mode
// - address decodes eight interface registers
// - auto-increment bumps address after internal access
// - broadcast bit makes bits 5:2 instruction
// - codes 0000,0001,0010,0100 select every device
// - codes 100x match identifier bit 0, 11xx both low bits; the rest select none
// - enables bits 0,2; activity bits 1,3
// - sync config: first-sync-only, edge enable
// - sync trigger: three enables, soft sync
// - data registers carry a 20-bit word
// - low data register access triggers internal access
// - separate strobe: ready low until done
// - data strobe: acknowledge low until strobe drops
`timescale 1ns/1ps
module host_microport
(
   input  wire  logic                i_sys_clk,
   input  wire  logic                i_rst_n,
   input  wire  logic                i_cs_n,
   input  wire  logic                i_rd_ds_n,
   input  wire  logic                i_wr_rw_n,
   input  wire  logic [2:0]          i_addr,
   input  wire  logic [7:0]          i_data,
   input  wire  logic [2:0]          i_mode,
   input  wire  logic [1:0]          i_strapped_device_identifier,
   output logic       [7:0]          o_data,
   output logic                      o_data_oe,
   output logic                      o_ready_ack,
   output hmp_pkg::int_req_t         o_int_req,
   input  wire  logic                i_int_done,
   input  wire  logic [19:0]         i_int_rdata,
   input  wire  logic [1:0]          i_chan_active,
   output hmp_pkg::chan_ctrl_t       o_ctrl
);
   import hmp_pkg::*;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   pins_t       pin_raw;
   pins_t       pin_s1_r;
   pins_t       pin_s2_r;
   pins_t       pin_s3_r;
   pins_t       pins_r;
   state_t      state_r;
   logic [7:0]  acc_ctrl_r;
   logic [7:0]  addr_low_r;
   logic [19:0] word_r;
   logic [7:0]  wbyte_r;
   logic [2:0]  acc_addr_r;
   logic        is_rd_r;
   logic        ign_r;
   chan_ctrl_t  ctrl_r;
   int_req_t    req_r;
   logic        sep;
   logic        dsm;
   logic        req_rd;
   logic        req_wr;
   logic        active;
   logic        selected;
   logic        start;
   logic        complete;
   logic [7:0]  rd_byte;

   assign pin_raw = {i_cs_n, i_rd_ds_n, i_wr_rw_n, i_addr, i_data, i_mode,
                     i_strapped_device_identifier};

   // three-stage chain; a change counts when stages two and three agree
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         pin_s1_r <= PINS_IDLE;
         pin_s2_r <= PINS_IDLE;
         pin_s3_r <= PINS_IDLE;
         pins_r   <= PINS_IDLE;
      end
      else
      begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         if (pin_s2_r == pin_s3_r)
            pins_r <= pin_s3_r;
      end
   end

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   // broadcast instruction decode against the strapped identifier
   function automatic logic bcast_accept(input logic [3:0] ins, input logic [1:0] id);
      case (ins)
         4'h0, 4'h1, 4'h2, 4'h4: bcast_accept = 1'b1;
         4'h8, 4'h9:             bcast_accept = (ins[0] == id[0]);
         4'hc, 4'hd, 4'he, 4'hf: bcast_accept = (ins[1:0] == id);
         default:                bcast_accept = 1'b0;
      endcase
   endfunction

   // strobe roles depend on the mode pins
   always_comb
   begin
      sep    = (pins_r.mode == MODE_SEP);
      dsm    = (pins_r.mode == MODE_DS);
      req_rd = !pins_r.cs_n && (sep ? !pins_r.rd_ds_n
                                    : dsm && !pins_r.rd_ds_n && pins_r.wr_rw_n);
      req_wr = !pins_r.cs_n && (sep ? !pins_r.wr_rw_n
                                    : dsm && !pins_r.rd_ds_n && !pins_r.wr_rw_n);
      active = req_rd || req_wr;
      selected = !acc_ctrl_r[ACC_BCAST] ||
                 bcast_accept(acc_ctrl_r[ACC_INSTR_LSB +: 4], pins_r.id);
      start    = (state_r == ST_IDLE) && active;
      complete = (state_r == ST_ACC && acc_addr_r != OFS_DATA_LOW) ||
                 (state_r == ST_INT && i_int_done);
   end

   // read mux, reserved bits read zero
   always_comb
   begin
      case (acc_addr_r)
         OFS_DATA_MID:  rd_byte = word_r[15:8];
         OFS_DATA_HIGH: rd_byte = {4'h0, word_r[19:16]};
         OFS_CHAN_EN:   rd_byte = {4'h0, i_chan_active[1], ctrl_r.chan_en[1],
                                   i_chan_active[0], ctrl_r.chan_en[0]};
         OFS_SYNC_CFG:  rd_byte = {2'h0, ctrl_r.first_sync_only, ctrl_r.edge_sens,
                                   3'h0, ctrl_r.pin_sync};
         OFS_SYNC_TRIG: rd_byte = {1'b0, ctrl_r.agc_sync_en, ctrl_r.dc_sync_en,
                                   ctrl_r.noise_sequence_sync_en, 4'h0};
         OFS_ADDR_LOW:  rd_byte = addr_low_r;
         OFS_ACC_CTRL:  rd_byte = acc_ctrl_r;
         default:       rd_byte = i_int_rdata[7:0];
      endcase
   end

   // ----------------------------------------
   // access sequencer
   // ----------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         state_r    <= ST_IDLE;
         ign_r      <= 1'b0;
         is_rd_r    <= 1'b0;
         acc_addr_r <= OFS_DATA_LOW;
         wbyte_r    <= REG_RESET;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
               if (active)
               begin
                  ign_r      <= !selected;
                  is_rd_r    <= req_rd;
                  acc_addr_r <= pins_r.addr;
                  wbyte_r    <= pins_r.data;
                  state_r    <= selected ? ST_ACC : ST_DONE;
               end
            ST_ACC:  state_r <= (acc_addr_r == OFS_DATA_LOW) ? ST_INT : ST_DONE;
            ST_INT:  if (i_int_done) state_r <= ST_DONE;
            ST_DONE: if (!active) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // interface registers
   // ----------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         acc_ctrl_r <= REG_RESET;
         addr_low_r <= REG_RESET;
         word_r     <= '0;
         ctrl_r     <= '0;
      end
      else
      begin
         ctrl_r.soft_sync <= 1'b0;
         if (state_r == ST_ACC && !is_rd_r)
         begin
            case (acc_addr_r)
               OFS_ACC_CTRL:  acc_ctrl_r <= wbyte_r;
               OFS_ADDR_LOW:  addr_low_r <= wbyte_r;
               OFS_DATA_LOW:  word_r[7:0] <= wbyte_r;
               OFS_DATA_MID:  word_r[15:8] <= wbyte_r;
               OFS_DATA_HIGH: word_r[19:16] <= wbyte_r[3:0];
               OFS_CHAN_EN:   ctrl_r.chan_en <= {wbyte_r[2], wbyte_r[0]};
               OFS_SYNC_CFG:
               begin
                  ctrl_r.first_sync_only <= wbyte_r[5];
                  ctrl_r.edge_sens       <= wbyte_r[4];
                  ctrl_r.pin_sync        <= wbyte_r[0];
               end
               default:
               begin
                  ctrl_r.agc_sync_en            <= wbyte_r[6];
                  ctrl_r.dc_sync_en             <= wbyte_r[5];
                  ctrl_r.noise_sequence_sync_en <= wbyte_r[4];
                  ctrl_r.soft_sync              <= wbyte_r[0];
               end
            endcase
         end
         if (state_r == ST_INT && i_int_done)
         begin
            if (is_rd_r)
               word_r <= i_int_rdata;
            if (acc_ctrl_r[ACC_AUTO_INC])
               addr_low_r <= addr_low_r + 8'h01;
         end
      end
   end
   // internal access request, one-cycle strobes
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         req_r <= '0;
      else
      begin
         req_r.rd <= 1'b0;
         req_r.wr <= 1'b0;
         if (state_r == ST_ACC && acc_addr_r == OFS_DATA_LOW)
         begin
            req_r.rd    <= is_rd_r;
            req_r.wr    <= !is_rd_r;
            req_r.addr  <= {acc_ctrl_r[1:0], addr_low_r};
            req_r.wdata <= {word_r[19:8], wbyte_r};
         end
      end
   end

   // ----------------------------------------
   // host-facing status and data drive
   // ----------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_ready_ack <= 1'b1;
         o_data_oe   <= 1'b0;
         o_data      <= 8'h00;
      end
      else
      begin
         if (start && selected && sep)
            o_ready_ack <= 1'b0;
         else if (complete)
            o_ready_ack <= !dsm;
         else if (state_r == ST_DONE && !active)
            o_ready_ack <= 1'b1;
         if (complete && is_rd_r)
         begin
            o_data_oe <= 1'b1;
            o_data    <= rd_byte;
         end
         else if (state_r == ST_DONE && !active)
            o_data_oe <= 1'b0;
      end
   end
   // request and control outputs come straight from their flops
   assign o_int_req = req_r;
   assign o_ctrl    = ctrl_r;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   chk_ready_low_start: assert property (start && selected && sep |=> !o_ready_ack)
      else $error("ready not pulled low at access start");
   chk_ready_release: assert property (complete && sep |=> o_ready_ack)
      else $error("ready not released at completion");
   chk_ack_on_done: assert property (complete && dsm |=> !o_ready_ack ##1 $stable(o_data))
      else $error("acknowledge not asserted at completion");
   chk_ack_release: assert property (state_r == ST_DONE && !active && dsm |=> o_ready_ack)
      else $error("acknowledge not released after strobe");
   chk_ignore_drive: assert property (ign_r && state_r == ST_DONE |-> !o_data_oe)
      else $error("unselected device drives data");
   chk_bcast_reject: assert property (start && !selected |=> ign_r && state_r == ST_DONE)
      else $error("rejected broadcast access not ignored");
   chk_low_trigger: assert property (state_r == ST_ACC && acc_addr_r == OFS_DATA_LOW
                                     && !is_rd_r |=> o_int_req.wr)
      else $error("low data write did not start internal write");
   chk_auto_inc: assert property (state_r == ST_INT && i_int_done && acc_ctrl_r[7]
                                  |=> addr_low_r == $past(addr_low_r) + 8'h01)
      else $error("address not incremented");
   chk_high_reserved: assert property (o_data_oe && acc_addr_r == OFS_DATA_HIGH
                                       |-> o_data[7:4] == 4'h0)
      else $error("reserved data bits read nonzero");
endmodule // host_microport

// File: tb/int_mem_model.sv
`timescale 1ns/1ps
module int_mem_model
import hmp_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire hmp_pkg::int_req_t i_req,
   input  wire logic [3:0]        i_dly,
   output logic                   o_done,
   output logic [19:0]            o_rdata
);
   logic [19:0] mem [1024];
   logic [3:0]  cnt;
   logic        busy;
   // start idle with a known read bus
   initial
   begin
      cnt = 4'h0;
      busy = 1'b0;
      o_done = 1'b0;
      o_rdata = 20'h5a5a5;
   end
   // one access at a time, answered after i_dly idle cycles
   always @(posedge i_sys_clk)
   begin
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;  // read bus never holds a stale word
      if (i_req.wr)
         mem[i_req.addr] <= i_req.wdata;
      if (i_req.rd | i_req.wr)
      begin
         busy <= 1'b1;
         cnt <= i_dly;
      end
      else if (busy)
      begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h0)
         begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_rdata <= mem[i_req.addr];
         end
      end
   end
endmodule  // int_mem_model

// File: tb/test_host_microport.sv
`timescale 1ns/1ps
module test_host_microport;
   import hmp_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n = 1'b1;
   logic        rd_ds_n = 1'b1;
   logic        wr_rw_n = 1'b1;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  host_d = 8'h00;
   logic [2:0]  mode = MODE_SEP;
   logic [1:0]  id = 2'b10;
   logic [1:0]  act = 2'b10;
   logic [3:0]  dly = 4'h7;
   logic [7:0]  dout;
   logic        oe;
   logic        rdy;
   logic        done;
   logic [19:0] rdata;
   int_req_t    req;
   chan_ctrl_t  ctrl;
   wire  logic [7:0] bus_d = oe ? dout : host_d;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cyc = 0;
   logic [7:0]  q;
   logic [7:0]  prev = 8'h00;
   logic [3:0]  c;
   logic        sel;
   logic        soft_seen = 1'b0;
   logic [3:0]  codes [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
   host_microport dut
   (
      .i_sys_clk(clk),
      .i_rst_n(rst_n),
      .i_cs_n(cs_n),
      .i_rd_ds_n(rd_ds_n),
      .i_wr_rw_n(wr_rw_n),
      .i_addr(addr),
      .i_data(bus_d),
      .i_mode(mode),
      .i_strapped_device_identifier(id),
      .o_data(dout),
      .o_data_oe(oe),
      .o_ready_ack(rdy),
      .o_int_req(req),
      .i_int_done(done),
      .i_int_rdata(rdata),
      .i_chan_active(act),
      .o_ctrl(ctrl)
   );
   int_mem_model u_mem
   (
      .i_sys_clk(clk),
      .i_req(req),
      .i_dly(dly),
      .o_done(done),
      .o_rdata(rdata)
   );
   // ----------------------------------------
   // compare and host access tasks
   // ----------------------------------------
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e)
         $display("mismatch at %0t: byte %h expected %h", $time, g, e);
      if (g !== e)
         miscompares++;
   endtask
   task automatic chk20(input logic [19:0] g, input logic [19:0] e);
      num_checks++;
      if (g !== e)
         $display("mismatch at %0t: word %h expected %h", $time, g, e);
      if (g !== e)
         miscompares++;
   endtask
   // one access; ign expects it to be refused with no answer
   task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] wd,
                      input logic ign, output logic [7:0] r);
      int   n;
      logic ds;
      n = 0;
      repeat (2) @(posedge clk);
      ds = (mode == MODE_DS);  // a mode set just before the call has landed by now
      cs_n <= 1'b0;
      addr <= a;
      host_d <= wd;
      rd_ds_n <= ~(rd | ds);
      wr_rw_n <= rd;
      if (ign)
         repeat (12)
         begin
            @(negedge clk);
            chk8({6'h0, oe, rdy}, 8'h01);
         end
      else
      begin
         do @(negedge clk); while (rdy !== 1'b0 && ++n < 80);
         if (!ds)
            do @(negedge clk); while (rdy !== 1'b1 && ++n < 80);
         chk8({7'h0, n < 80}, 8'h01);
      end
      r = dout;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_ds_n <= 1'b1;
      wr_rw_n <= 1'b1;
      host_d <= ~wd;
      do @(negedge clk); while (rdy !== 1'b1 && ++n < 160);
      repeat (4) @(posedge clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b0, a, d, 1'b0, q);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      acc(1'b1, a, 8'h00, 1'b0, q);
      chk8(q, e);
   endtask
   task automatic wrc(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
      wr(a, d);
      rdc(a, e);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // clock, timeout and test sequence
   // ----------------------------------------
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (ctrl.soft_sync)
         soft_seen <= 1'b1;
      if (cyc == 20000)
      begin
         miscompares++;
         finish_test;
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 1; a < 8; a++)
         rdc(a[2:0], (a == 3) ? 8'h08 : 8'h00);
      $display("test reset_values done");
      wrc(OFS_CHAN_EN, 8'hff, 8'h0d);
      wrc(OFS_SYNC_CFG, 8'hff, 8'h31);
      wrc(OFS_SYNC_TRIG, 8'hff, 8'h70);
      chk8({7'h0, soft_seen}, 8'h01);
      wrc(OFS_DATA_HIGH, 8'hff, 8'h0f);
      wrc(OFS_DATA_MID, 8'h5c, 8'h5c);
      chk20({11'h0, ctrl}, 20'h001fe);
      $display("test registers done");
      wrc(OFS_ACC_CTRL, 8'h80, 8'h80);
      wrc(OFS_ADDR_LOW, 8'h10, 8'h10);
      wr(OFS_DATA_HIGH, 8'h0a);
      wr(OFS_DATA_MID, 8'hbc);
      wr(OFS_DATA_LOW, 8'hde);
      chk20(u_mem.mem[16], 20'habcde);
      rdc(OFS_ADDR_LOW, 8'h11);
      dly <= 4'h0;
      wr(OFS_ADDR_LOW, 8'h10);
      rdc(OFS_DATA_LOW, 8'hde);
      rdc(OFS_DATA_MID, 8'hbc);
      rdc(OFS_DATA_HIGH, 8'h0a);
      $display("test internal_access done");
      mode <= MODE_DS;
      wr(OFS_ADDR_LOW, 8'h20);
      wr(OFS_DATA_HIGH, 8'h03);
      wr(OFS_DATA_MID, 8'h44);
      wr(OFS_DATA_LOW, 8'h55);
      chk20(u_mem.mem[32], 20'h34455);
      wr(OFS_ADDR_LOW, 8'h20);
      rdc(OFS_DATA_LOW, 8'h55);
      rdc(OFS_ADDR_LOW, 8'h21);
      mode <= MODE_SEP;
      $display("test data_strobe done");
      foreach (codes[k])
      begin
         c = codes[k];
         sel = (c inside {4'h0, 4'h1, 4'h2, 4'h4}) || (c[3:1] == 3'b100 && c[0] == id[0])
               || (c[3:2] == 2'b11 && c[1:0] == id);
         wr(OFS_ACC_CTRL, {2'b01, c, 2'b00});
         acc(1'b0, OFS_ADDR_LOW, {c, 4'h3}, !sel, q);
         id <= c[1:0];
         wr(OFS_ACC_CTRL, 8'h00);
         id <= 2'b10;
         if (sel)
            prev = {c, 4'h3};
         rdc(OFS_ADDR_LOW, prev);
      end
      $display("test broadcast done");
      mode <= 3'h2;
      acc(1'b0, OFS_ADDR_LOW, 8'h77, 1'b1, q);
      mode <= MODE_SEP;
      rdc(OFS_ADDR_LOW, prev);
      $display("test unknown_mode done");
      finish_test;
   end
endmodule  // test_host_microport
